// file: common/ccd_pkg.sv
// Shared constants and types for the CPU clock divider control block
package ccd_pkg;
   // Divider code field
   localparam int DIV_W = 3;
   localparam logic [2:0] DIV_MAX = 3'h4;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   localparam int PHASE_W = 4;
   // Switchover latency, in instructions, when leaving the undivided code
   localparam int LAT_W = 5;
   localparam logic [4:0] LAT_BASE = 5'h10;
   // Register byte addresses on the bus
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_SET = 4'h8;
   localparam logic [3:0] ADDR_CLR = 4'hc;
   // Status register field positions
   localparam int ST_CODE_LSB = 0;
   localparam int ST_PEND_BIT = 3;
   localparam int ST_STAB_BIT = 4;
   localparam int ST_HALT_BIT = 5;
   localparam int ST_STOP_BIT = 6;
   localparam int ST_OSC_BIT = 7;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Clock rate; sys_clk is the main oscillator clock itself
   localparam int CLK_MHZ = 125;
   localparam int CLK_PER_OSC = 1;
   // Oscillation stabilization wait, in main clock periods
   localparam int STAB_PERIODS = 131072;
   localparam int STAB_CYCLES = STAB_PERIODS * CLK_PER_OSC;
   localparam int STAB_W = 18;
   // Operating modes of the clock generator
   typedef enum logic [1:0] {MODE_STAB, MODE_RUN, MODE_HALT, MODE_STOP} ccd_mode_t;
endpackage

// file: core/ccd_divider.sv
// Phase counter that turns the main clock into CPU clock ticks
`timescale 1ns/1ps
module ccd_divider (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic run, // Oscillator running
   input wire logic [ccd_pkg::DIV_W-1:0] code, // Active divider code
   output logic tick // Last main cycle of a CPU period
);
   logic [ccd_pkg::PHASE_W-1:0] phase; // Position inside the CPU period
   logic [ccd_pkg::PHASE_W-1:0] next_phase;
   logic [ccd_pkg::PHASE_W-1:0] mask; // Period length minus one

   // Period length from the code: 1, 2, 4, 8 or 16 main cycles
   always_comb begin
      unique case (code)
         3'h0: mask = 4'h0; // RQ1
         3'h1: mask = 4'h1; // RQ1
         3'h2: mask = 4'h3; // RQ1
         3'h3: mask = 4'h7; // RQ1
         default: mask = 4'hf; // RQ1
      endcase
   end

   // Tick only on a full period, so a new code starts on phase zero
   always_comb begin
      tick = run && (phase >= mask);
      next_phase = phase;
      if (tick) begin
         next_phase = '0; // RQ11
      end else if (run) begin
         next_phase = phase + 4'h1;
      end
   end

   // Phase register, frozen while the oscillator is stopped
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         phase <= '0;
      end else begin
         phase <= next_phase;
      end
   end
endmodule

// file: core/ccd_switch.sv
// Delayed switchover of the active divider code
`timescale 1ns/1ps
module ccd_switch (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic reqValid, // New legal code written
   input wire logic [ccd_pkg::DIV_W-1:0] reqCode, // Code written
   input wire logic instrDone, // One instruction completed
   input wire logic tick, // CPU period boundary
   output logic [ccd_pkg::DIV_W-1:0] activeCode, // Code in use
   output logic pending // Switchover under way
);
   logic [ccd_pkg::DIV_W-1:0] pendCode; // Code waiting to take over
   logic [ccd_pkg::LAT_W-1:0] left; // Instructions still to run
   logic [ccd_pkg::DIV_W-1:0] next_activeCode;
   logic [ccd_pkg::DIV_W-1:0] next_pendCode;
   logic next_pending;
   logic [ccd_pkg::LAT_W-1:0] next_left;

   // Latency from the code being left; switch at a period boundary
   always_comb begin
      next_activeCode = activeCode;
      next_pendCode = pendCode;
      next_pending = pending;
      next_left = left;
      if (reqValid) begin
         // A later write restarts the wait from the code in use
         next_pendCode = reqCode;
         next_pending = 1'b1;
         next_left = ccd_pkg::LAT_BASE >> activeCode; // RQ5
      end else if (pending) begin
         if (left != '0) begin
            // Old ratio stays in force while instructions run
            if (instrDone) begin
               next_left = left - 5'h1; // RQ4
            end
         end else if (tick) begin
            next_activeCode = pendCode; // RQ11
            next_pending = 1'b0;
         end
      end
   end

   // Switchover state registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         activeCode <= ccd_pkg::CTRL_RESET; // RQ2
         pendCode <= ccd_pkg::CTRL_RESET;
         pending <= 1'b0;
         left <= '0;
      end else begin
         activeCode <= next_activeCode;
         pendCode <= next_pendCode;
         pending <= next_pending;
         left <= next_left;
      end
   end
endmodule

// file: core/ccd_top.sv
// CPU clock divider control: bus registers, standby modes, CPU clock enable
//
// How it works
// RQ1: Divider codes 0..4 give divide by 1..16.
// RQ2: Reset loads control register with 04H.
// RQ3: Software keeps control bits three to seven zero.
// RQ4: Old ratio runs on for some instructions.
// RQ5: Delay is 16,8,4,2,1 by old code.
// RQ6: Wait 2^17 main periods before CPU runs.
// RQ7: Oscillator stays off while reset is low.
// RQ8: STOP halts oscillator, CPU and peripheral clocks.
// RQ9: STOP and HALT standby states are offered.
// RQ10: Register takes single-bit and whole-byte writes.
// RQ11: Ratio changes only on a full period boundary.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ccd_top #(
   parameter int STAB_CYCLES = ccd_pkg::STAB_CYCLES // Stabilization wait
) (
   input wire logic sys_clk, // Main oscillator clock
   input wire logic resetn, // Asynchronous reset, active low
   // AXI4-Lite write address
   input wire logic [ccd_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [ccd_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // CPU side
   input wire logic instrDone, // One instruction completed
   input wire logic stopExec, // STOP instruction executed
   input wire logic haltExec, // HALT instruction executed
   input wire logic wakeReq, // Release from standby
   output logic oscEnable, // Main oscillator runs
   output logic cpuClkEn, // One pulse per CPU clock period
   output logic periphClkEn, // Peripheral clock running
   output logic cpuRun // CPU may fetch
);
   // Write channel state
   logic awHave; // Write address held
   logic wHave; // Write data held
   logic [ccd_pkg::ADDR_W-1:0] awAddrQ; // Held write address
   logic [31:0] wDataQ; // Held write data
   logic [3:0] wStrbQ; // Held byte strobes
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_awHave;
   logic next_wHave;
   logic [ccd_pkg::ADDR_W-1:0] next_awAddrQ;
   logic [31:0] next_wDataQ;
   logic [3:0] next_wStrbQ;
   wire logic doWrite = awHave && wHave && !bvalid; // Address and data both held

   // Read channel state
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   // Control register and request to the switchover logic
   logic [ccd_pkg::DIV_W-1:0] ctrl; // Divider field as written
   logic [ccd_pkg::DIV_W-1:0] next_ctrl;
   logic reqValid; // Legal code written
   logic next_reqValid;
   logic [ccd_pkg::DIV_W-1:0] reqCode;
   logic [ccd_pkg::DIV_W-1:0] next_reqCode;
   logic wrErr; // Write to an unmapped address

   // Mode state
   ccd_pkg::ccd_mode_t mode; // Current operating mode
   ccd_pkg::ccd_mode_t next_mode;
   logic [ccd_pkg::STAB_W-1:0] stabCnt; // Stabilization counter
   logic [ccd_pkg::STAB_W-1:0] next_stabCnt;
   logic next_oscEnable;
   logic next_cpuClkEn;
   logic next_periphClkEn;
   logic next_cpuRun;

   // Links to the submodules
   logic tick; // CPU period boundary
   logic [ccd_pkg::DIV_W-1:0] activeCode; // Code in use
   logic pending; // Switchover under way
   logic [31:0] statusWord; // Status register image

   // Write channel: address and data taken in either order
   always_comb begin
      next_awHave = awHave;
      next_wHave = wHave;
      next_awAddrQ = awAddrQ;
      next_wDataQ = wDataQ;
      next_wStrbQ = wStrbQ;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (awvalid && awready) begin
         // Address taken
         next_awHave = 1'b1;
         next_awAddrQ = awaddr;
      end
      if (wvalid && wready) begin
         // Data taken
         next_wHave = 1'b1;
         next_wDataQ = wdata;
         next_wStrbQ = wstrb;
      end
      if (doWrite) begin
         // Both held: commit and answer
         next_awHave = 1'b0;
         next_wHave = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wrErr ? ccd_pkg::RESP_SLVERR : ccd_pkg::RESP_OKAY;
      end else if (bvalid && bready) begin
         // Response accepted
         next_bvalid = 1'b0;
      end
      next_awready = !next_awHave && !next_bvalid;
      next_wready = !next_wHave && !next_bvalid;
   end

   // Write channel registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= ccd_pkg::RESP_OKAY;
         awHave <= 1'b0;
         wHave <= 1'b0;
         awAddrQ <= '0;
         wDataQ <= '0;
         wStrbQ <= '0;
      end else begin
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         awHave <= next_awHave;
         wHave <= next_wHave;
         awAddrQ <= next_awAddrQ;
         wDataQ <= next_wDataQ;
         wStrbQ <= next_wStrbQ;
      end
   end

   // Control register: whole write, bit set and bit clear views
   always_comb begin
      next_ctrl = ctrl;
      wrErr = 1'b0;
      unique case (awAddrQ)
         ccd_pkg::ADDR_CTRL: begin
            // Whole field write
            if (wStrbQ[0]) begin
               next_ctrl = wDataQ[ccd_pkg::DIV_W-1:0]; // RQ10
            end
         end
         ccd_pkg::ADDR_SET: begin
            // Single bits set, others kept
            if (wStrbQ[0]) begin
               next_ctrl = ctrl | wDataQ[ccd_pkg::DIV_W-1:0]; // RQ10
            end
         end
         ccd_pkg::ADDR_CLR: begin
            // Single bits cleared, others kept
            if (wStrbQ[0]) begin
               next_ctrl = ctrl & ~wDataQ[ccd_pkg::DIV_W-1:0]; // RQ10
            end
         end
         ccd_pkg::ADDR_STATUS: begin
            // Read-only; ctrl kept, but a write with wStrbQ[0] set re-requests a legal ctrl code
            next_ctrl = ctrl;
         end
         default: begin
            wrErr = 1'b1;
         end
      endcase
      if (!doWrite) begin
         next_ctrl = ctrl;
      end
      // Prohibited codes are stored but never reach the divider
      next_reqValid = doWrite && !wrErr && wStrbQ[0] && (next_ctrl <= ccd_pkg::DIV_MAX); // RQ1
      next_reqCode = next_ctrl;
   end

   // Control register state
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= ccd_pkg::CTRL_RESET; // RQ2
         reqValid <= 1'b0;
         reqCode <= ccd_pkg::CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
         reqValid <= next_reqValid;
         reqCode <= next_reqCode;
      end
   end

   // Status image: code in use, pending switch, mode, oscillator
   always_comb begin
      statusWord = '0;
      statusWord[ccd_pkg::ST_CODE_LSB +: ccd_pkg::DIV_W] = activeCode;
      statusWord[ccd_pkg::ST_PEND_BIT] = pending;
      statusWord[ccd_pkg::ST_STAB_BIT] = (mode == ccd_pkg::MODE_STAB);
      statusWord[ccd_pkg::ST_HALT_BIT] = (mode == ccd_pkg::MODE_HALT);
      statusWord[ccd_pkg::ST_STOP_BIT] = (mode == ccd_pkg::MODE_STOP);
      statusWord[ccd_pkg::ST_OSC_BIT] = oscEnable;
   end

   // Read channel: one read at a time, answer one cycle after the address
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = ccd_pkg::RESP_OKAY;
         unique case (araddr)
            ccd_pkg::ADDR_CTRL: next_rdata = {29'h0, ctrl};
            ccd_pkg::ADDR_STATUS: next_rdata = statusWord;
            ccd_pkg::ADDR_SET: next_rdata = '0;
            ccd_pkg::ADDR_CLR: next_rdata = '0;
            default: begin
               // Unmapped address
               next_rdata = '0;
               next_rresp = ccd_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      next_arready = !next_rvalid;
   end

   // Read channel registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= ccd_pkg::RESP_OKAY;
      end else begin
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // Mode sequencing: stabilization, run and the two standby states
   always_comb begin
      next_mode = mode;
      next_stabCnt = stabCnt;
      next_oscEnable = oscEnable;
      unique case (mode)
         ccd_pkg::MODE_STAB: begin
            // Oscillator starts, CPU waits for the count
            next_oscEnable = 1'b1;
            if (oscEnable) begin
               if (stabCnt == ccd_pkg::STAB_W'(STAB_CYCLES - 1)) begin
                  next_mode = ccd_pkg::MODE_RUN; // RQ6
                  next_stabCnt = '0;
               end else begin
                  next_stabCnt = stabCnt + 18'h1; // RQ6
               end
            end
         end
         ccd_pkg::MODE_RUN: begin
            // STOP wins if both standby requests arrive together
            if (stopExec) begin
               next_mode = ccd_pkg::MODE_STOP; // RQ9
               next_oscEnable = 1'b0; // RQ8
            end else if (haltExec) begin
               next_mode = ccd_pkg::MODE_HALT; // RQ9
            end
         end
         ccd_pkg::MODE_HALT: begin
            // Oscillator and peripherals keep running
            if (wakeReq) begin
               next_mode = ccd_pkg::MODE_RUN;
            end
         end
         ccd_pkg::MODE_STOP: begin
            // Restart needs a fresh stabilization wait
            if (wakeReq) begin
               next_mode = ccd_pkg::MODE_STAB;
               next_stabCnt = '0;
            end
         end
      endcase
      next_cpuRun = (next_mode == ccd_pkg::MODE_RUN);
      next_cpuClkEn = tick && (mode == ccd_pkg::MODE_RUN);
      next_periphClkEn = (next_mode == ccd_pkg::MODE_RUN) || (next_mode == ccd_pkg::MODE_HALT); // RQ8
   end

   // Mode registers; oscillator held off throughout reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode <= ccd_pkg::MODE_STAB;
         stabCnt <= '0;
         oscEnable <= 1'b0; // RQ7
         cpuClkEn <= 1'b0;
         periphClkEn <= 1'b0;
         cpuRun <= 1'b0;
      end else begin
         mode <= next_mode;
         stabCnt <= next_stabCnt;
         oscEnable <= next_oscEnable;
         cpuClkEn <= next_cpuClkEn;
         periphClkEn <= next_periphClkEn;
         cpuRun <= next_cpuRun;
      end
   end

   // CPU period counter, stopped with the oscillator
   ccd_divider u_divider (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .run(oscEnable),
      .code(activeCode),
      .tick(tick)
   );

   // Instruction-counted switchover of the code in use
   ccd_switch u_switch (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .reqValid(reqValid),
      .reqCode(reqCode),
      .instrDone(instrDone),
      .tick(tick),
      .activeCode(activeCode),
      .pending(pending)
   );
endmodule

// file: verif/ccd_chk.sv
// Checker of port timing for the CPU clock divider control block
`timescale 1ns/1ps
module ccd_chk #(
   parameter int STAB_CYCLES = 16 // Stabilization wait in main cycles
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic stopExec,
   input wire logic haltExec,
   input wire logic oscEnable,
   input wire logic cpuClkEn,
   input wire logic periphClkEn,
   input wire logic cpuRun
);
   int oscCnt; // Cycles since the oscillator last started
   int next_oscCnt; // Next value of the running count
   // Count running cycles, cleared while the oscillator is off
   always_comb begin
      next_oscCnt = oscEnable ? oscCnt + 1 : 0;
   end
   // Register the running count
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         oscCnt <= 0;
      end else begin
         oscCnt <= next_oscCnt;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Both write halves taken at one edge
   sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
   // Oscillator, CPU run and peripheral clock all stopped
   sequence s_all_off; !oscEnable && !cpuRun && !periphClkEn; endsequence
   property p_stop; cpuRun && stopExec |=> s_all_off; endproperty
   a_stop: assert property (p_stop) else $error("stop left a clock running");
   property p_halt; cpuRun && haltExec && !stopExec |=> !cpuRun && periphClkEn && oscEnable; endproperty
   a_halt: assert property (p_halt) else $error("halt state wrong");
   property p_quiet; !oscEnable ##1 !oscEnable |-> !cpuClkEn && !cpuRun; endproperty
   a_quiet: assert property (p_quiet) else $error("cpu clock while oscillator off");
   property p_stab_min; $rose(cpuRun) |-> oscCnt >= STAB_CYCLES; endproperty
   a_stab_min: assert property (p_stab_min) else $error("cpu started before stabilization");
   property p_stab_max; oscEnable && !periphClkEn |-> oscCnt <= STAB_CYCLES + 4; endproperty
   a_stab_max: assert property (p_stab_max) else $error("stabilization wait too long");
   property p_wr_resp; s_wr_taken |-> ##2 bvalid; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_resp; arvalid && arready |=> rvalid; endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read data late");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule
bind ccd_top ccd_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
   .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rvalid(rvalid), .rready(rready), .stopExec(stopExec), .haltExec(haltExec),
   .oscEnable(oscEnable), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .cpuRun(cpuRun));

// file: verif/cpu_clock_divider_control_tb.sv
// Self-checking bench for the CPU clock divider control block
`timescale 1ns/1ps
module cpu_clock_divider_control_tb;
   localparam int STAB = 16; // Shortened stabilization wait
   typedef struct packed {logic [31:0] d; logic [1:0] r;} ccd_exp_t;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [3:0] araddr = 4'h0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic instrDone = 1'b0;
   logic stopExec = 1'b0;
   logic haltExec = 1'b0;
   logic wakeReq = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, oscEnable, cpuClkEn, periphClkEn, cpuRun;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   ccd_exp_t rq[$]; // Expected read answers, oldest first
   logic [1:0] bq[$]; // Expected write responses
   int mismatches = 0;
   int nChecks = 0;
   int cycles = 0;
   int seed = 32'h7d8b;
   ccd_top #(.STAB_CYCLES(STAB)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .instrDone(instrDone), .stopExec(stopExec), .haltExec(haltExec),
      .wakeReq(wakeReq), .oscEnable(oscEnable), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
      .cpuRun(cpuRun));
   // Compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Print counts and verdict, then stop
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Bus write: both halves offered together, released as each is taken
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge sys_clk);
         if (awready && !awDone) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !wDone) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // Random delay before ready; one idle edge after
      repeat ($unsigned($random(seed)) % 3) @(posedge sys_clk);
      bready <= 1'b1;
      do @(posedge sys_clk); while (!bvalid);
      bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Bus read; the answer is judged by the monitor
   task automatic axi_read(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back('{d: d, r: r});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      repeat ($unsigned($random(seed)) % 3) @(posedge sys_clk);
      rready <= 1'b1;
      do @(posedge sys_clk); while (!rvalid);
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Completed-instruction pulses with random gaps
   task automatic instr(input int n);
      repeat (n) begin
         instrDone <= 1'b1;
         @(posedge sys_clk);
         instrDone <= 1'b0;
         repeat (1 + ($unsigned($random(seed)) % 3)) @(posedge sys_clk);
      end
   endtask
   // Measure main cycles between two CPU clock pulses
   task automatic period(input int exp);
      int n;
      n = 0;
      do @(posedge sys_clk); while (!cpuClkEn);
      do begin
         @(posedge sys_clk);
         n++;
      end while (!cpuClkEn && n < 64);
      check(n, exp);
   endtask
   // Count edges until the CPU may fetch
   task automatic wait_run(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (!cpuRun && n < 200);
   endtask
   // Status word while running: oscillator on, pending flag, active code
   function automatic logic [31:0] st(input logic [2:0] c, input logic p);
      return {24'h0, 4'h8, p, c};
   endfunction
   // Monitor: every bus answer is matched with the oldest expectation
   always @(posedge sys_clk) begin
      if (rvalid && rready) begin
         check(rdata, rq.size() > 0 ? rq[0].d : 32'hdead);
         check(32'(rresp), rq.size() > 0 ? 32'(rq[0].r) : 32'h3);
         if (rq.size() > 0) void'(rq.pop_front());
      end
      if (bvalid && bready) begin
         check(32'(bresp), bq.size() > 0 ? 32'(bq[0]) : 32'h3);
         if (bq.size() > 0) void'(bq.pop_front());
      end
   end
   // Main clock, 8 ns period
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         end_sim();
      end
   end
   // Main sequence
   initial begin
      int n;
      logic [2:0] old;
      logic [2:0] nc;
      old = 3'h4;
      repeat (10) @(posedge sys_clk);
      check(32'({oscEnable, cpuRun}), 32'h0);
      resetn <= 1'b1;
      wait_run(n);
      check(32'(n >= STAB + 1 && n <= STAB + 4), 32'h1);
      axi_read(ccd_pkg::ADDR_CTRL, 32'h4, ccd_pkg::RESP_OKAY);
      axi_read(ccd_pkg::ADDR_STATUS, st(3'h4, 1'b0), ccd_pkg::RESP_OKAY);
      period(16);
      $display("reset test done");
      // Leave every code once; old ratio holds until its count is used up
      for (int i = 0; i < 5; i++) begin
         nc = 3'(i);
         axi_write(ccd_pkg::ADDR_CTRL, {29'h0, nc}, 4'hf, ccd_pkg::RESP_OKAY);
         instr((16 >> old) - 1);
         repeat (40) @(posedge sys_clk);
         axi_read(ccd_pkg::ADDR_STATUS, st(old, 1'b1), ccd_pkg::RESP_OKAY);
         instr(1);
         repeat (40) @(posedge sys_clk);
         axi_read(ccd_pkg::ADDR_STATUS, st(nc, 1'b0), ccd_pkg::RESP_OKAY);
         period(1 << nc);
         old = nc;
      end
      $display("switch test done");
      // Prohibited code, bit writes, masked and misplaced writes
      axi_write(ccd_pkg::ADDR_CTRL, 32'h5, 4'h1, ccd_pkg::RESP_OKAY);
      instr(2);
      axi_read(ccd_pkg::ADDR_CTRL, 32'h5, ccd_pkg::RESP_OKAY);
      axi_read(ccd_pkg::ADDR_STATUS, st(3'h4, 1'b0), ccd_pkg::RESP_OKAY);
      axi_write(ccd_pkg::ADDR_CLR, 32'h1, 4'h1, ccd_pkg::RESP_OKAY);
      axi_write(ccd_pkg::ADDR_SET, 32'h2, 4'h1, ccd_pkg::RESP_OKAY);
      axi_read(ccd_pkg::ADDR_CTRL, 32'h6, ccd_pkg::RESP_OKAY);
      axi_write(ccd_pkg::ADDR_CLR, 32'h2, 4'h1, ccd_pkg::RESP_OKAY);
      axi_write(ccd_pkg::ADDR_CTRL, 32'h0, 4'h0, ccd_pkg::RESP_OKAY);
      axi_write(ccd_pkg::ADDR_STATUS, 32'h0, 4'hf, ccd_pkg::RESP_OKAY);
      axi_write(4'h2, 32'h0, 4'hf, ccd_pkg::RESP_SLVERR);
      instr(1);
      repeat (40) @(posedge sys_clk);
      axi_read(ccd_pkg::ADDR_CTRL, 32'h4, ccd_pkg::RESP_OKAY);
      axi_read(ccd_pkg::ADDR_STATUS, st(3'h4, 1'b0), ccd_pkg::RESP_OKAY);
      axi_read(ccd_pkg::ADDR_SET, 32'h0, ccd_pkg::RESP_OKAY);
      axi_read(4'h2, 32'h0, ccd_pkg::RESP_SLVERR);
      $display("register test done");
      // Halt keeps the oscillator and peripherals, wake resumes at once
      haltExec <= 1'b1;
      @(posedge sys_clk);
      haltExec <= 1'b0;
      @(posedge sys_clk);
      check(32'({cpuRun, periphClkEn, oscEnable}), 32'h3);
      axi_read(ccd_pkg::ADDR_STATUS, 32'ha4, ccd_pkg::RESP_OKAY);
      wakeReq <= 1'b1;
      @(posedge sys_clk);
      wakeReq <= 1'b0;
      @(posedge sys_clk);
      check(32'(cpuRun), 32'h1);
      // Stop kills every clock until wake and a fresh stabilization wait
      stopExec <= 1'b1;
      @(posedge sys_clk);
      stopExec <= 1'b0;
      @(posedge sys_clk);
      check(32'({cpuRun, periphClkEn, oscEnable}), 32'h0);
      n = 0;
      repeat (40) begin
         @(posedge sys_clk);
         n += int'(cpuClkEn);
      end
      check(n, 0);
      axi_read(ccd_pkg::ADDR_STATUS, 32'h44, ccd_pkg::RESP_OKAY);
      wakeReq <= 1'b1;
      @(posedge sys_clk);
      wakeReq <= 1'b0;
      wait_run(n);
      check(32'(n >= STAB && n <= STAB + 4), 32'h1);
      period(16);
      $display("standby test done");
      end_sim();
   end
endmodule
